/* File: cld_edge_if.sv */
// Interface carrying synchronised levels and edges of the timing pins
// Assumes a single clock domain; the sync module drives, the core reads
`timescale 1ns/1ns
interface cld_edge_if;
  import cld_pkg::*;
  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* File: cld_monitor.sv */
// Checker bound to the sensor core ports
// Assumes pins change 1 ns after a sys_clk edge
`timescale 1ns/1ns
module cld_monitor
  import cld_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                vertical_shift_reg,
  input wire logic                line_dump_ctl,
  input wire logic                hreg_output_clock,
  input wire logic                senseResetPulse,
  input wire logic                ref_sample_pulse,
  input wire logic                sig_sample_pulse,
  input wire logic                holdTransferPulse,
  input wire logic                shutter_trigger,
  input wire logic [CHARGE_W-1:0] rowLevel,
  input wire logic [CHARGE_W-1:0] video_out_ref,
  input wire logic [CHARGE_W-1:0] video_out_sig,
  input wire logic [DUMP_W-1:0]   dumpedRows,
  input wire logic [PIX_W-1:0]    pixelsLeft,
  input wire logic                hregBloom,
  input wire logic                readoutNoise
);
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pin edges act 3 clocks late because of the synchroniser
  property p_drain;
    $rose(vertical_shift_reg) && line_dump_ctl |-> ##[2:5] $changed(dumpedRows);
  endproperty
  a_drain: assert property (p_drain) else $error("dump shift not counted");
  property p_load;
    $rose(vertical_shift_reg) && !line_dump_ctl |-> ##[2:5] pixelsLeft == HREG_LEN;
  endproperty
  a_load: assert property (p_load) else $error("row not loaded");
  property p_pixel;
    $fell(hreg_output_clock) && pixelsLeft != PIX_ZERO |-> ##[2:5] $changed(pixelsLeft);
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel not moved");
  property p_ref;
    $rose(holdTransferPulse) |-> ##[2:5] video_out_ref == REF_LEVEL;
  endproperty
  a_ref: assert property (p_ref) else $error("reference level wrong");
  property p_hold;
    $changed(video_out_sig) |-> $past(holdTransferPulse, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without transfer");
  cover property ($rose(hregBloom));
  cover property (dumpedRows == 11'h002);
  cover property ($rose(readoutNoise));
endmodule // cld_monitor

bind cld_sensor_core cld_monitor i_mon (
  .sys_clk(sys_clk), .rst(rst), .vertical_shift_reg(vertical_shift_reg),
  .line_dump_ctl(line_dump_ctl), .hreg_output_clock(hreg_output_clock),
  .senseResetPulse(senseResetPulse), .ref_sample_pulse(ref_sample_pulse),
  .sig_sample_pulse(sig_sample_pulse), .holdTransferPulse(holdTransferPulse),
  .shutter_trigger(shutter_trigger), .rowLevel(rowLevel), .video_out_ref(video_out_ref),
  .video_out_sig(video_out_sig), .dumpedRows(dumpedRows), .pixelsLeft(pixelsLeft),
  .hregBloom(hregBloom), .readoutNoise(readoutNoise)
);

/* File: cld_pin_sync.sv */
// Two-flop synchroniser and edge detector for all timing pins
// Assumes pins are asynchronous to sys_clk and pulses last at least three clock periods
`timescale 1ns/1ns
module cld_pin_sync
  import cld_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [PIN_COUNT-1:0] pinsIn,
  cld_edge_if.src                   edges
);
  logic [PIN_COUNT-1:0] meta_reg;
  logic [PIN_COUNT-1:0] sync_reg;
  logic [PIN_COUNT-1:0] last_reg;

  // ----------------------------------------------------------------
  // Synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= pinsIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign edges.level = sync_reg;
  assign edges.rise  = sync_reg & ~last_reg;
  assign edges.fall  = ~sync_reg & last_reg;
endmodule // cld_pin_sync

/* File: cld_pkg.sv */
// Package with sizes, levels and pin indices for the line dump / binning / double sampler model
// Assumes one 100 MHz system clock and timing inputs that arrive asynchronously from pins
package cld_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          PIN_COUNT   = 7;
  localparam int          CHARGE_W    = 14;
  localparam int          PIX_W       = 11;
  localparam int          DUMP_W      = 11;
  localparam logic [10:0] HREG_LEN    = 11'h40C;   // 1036 cells
  localparam logic [10:0] HREG_EDGE   = 11'h008;   // Empty cells at the start only
  localparam logic [10:0] HREG_COLS   = 11'h404;   // 1028 cells fed by columns
  localparam logic [13:0] FULL_ROW    = 14'h0FFF;  // One row of full signal
  localparam logic [13:0] HREG_CAP    = 14'h1FFE;  // Two full rows hold without blooming
  localparam logic [13:0] REF_LEVEL   = 14'h0000;
  localparam logic [10:0] PIX_ZERO    = 11'h000;
  localparam logic [10:0] DUMP_ZERO   = 11'h000;
  localparam logic [10:0] ONE_PIX     = 11'h001;
  // ----------------------------------------------------------------
  // Timing pin indices
  // ----------------------------------------------------------------
  localparam int PIN_VSHIFT = 0;
  localparam int PIN_DUMP   = 1;
  localparam int PIN_HCLK   = 2;
  localparam int PIN_RESET  = 3;
  localparam int PIN_REFS   = 4;
  localparam int PIN_SIGS   = 5;
  localparam int PIN_XFER   = 6;
endpackage

/* File: cld_sensor_core.sv */
// Sensor-side model: fast line dump drain, row binning in the horizontal register,
// and the double sampler chain that presents each pixel on the video outputs
// Assumes timing pins driven by an external generator; rowLevel is the charge of each row
//
// Overview of operation
// - Dump high: vertical shift drains row
// - Falling output clock moves charge to sense
// - Reset sets reference; reference sample follows
// - Signal sample, then transfer from hold to outputs
// - Outputs lag one pixel period
`timescale 1ns/1ns
module cld_sensor_core
  import cld_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                vertical_shift_reg,
  input  wire logic                line_dump_ctl,
  input  wire logic                hreg_output_clock,
  input  wire logic                senseResetPulse,
  input  wire logic                ref_sample_pulse,
  input  wire logic                sig_sample_pulse,
  input  wire logic                holdTransferPulse,
  input  wire logic                shutter_trigger,
  input  wire logic [CHARGE_W-1:0] rowLevel,
  output logic      [CHARGE_W-1:0] video_out_ref,
  output logic      [CHARGE_W-1:0] video_out_sig,
  output logic      [DUMP_W-1:0]   dumpedRows,
  output logic      [PIX_W-1:0]    pixelsLeft,
  output logic                     hregBloom,
  output logic                     readoutNoise
);
  cld_edge_if edges ();

  cld_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinsIn  ({holdTransferPulse, sig_sample_pulse, ref_sample_pulse, senseResetPulse,
               hreg_output_clock, line_dump_ctl, vertical_shift_reg}),
    .edges   (edges)
  );

  // Shutter pin only feeds a status flag, so it gets its own two flops
  logic shutMeta_reg;
  logic shutSync_reg;

  logic [CHARGE_W-1:0] lineCharge_reg;
  logic [CHARGE_W-1:0] lineCharge_next;
  logic [PIX_W-1:0]    pixIdx_reg;
  logic [PIX_W-1:0]    pixIdx_next;
  logic [DUMP_W-1:0]   dumped_reg;
  logic [CHARGE_W-1:0] sense_reg;
  logic [CHARGE_W-1:0] refHold_reg;
  logic [CHARGE_W-1:0] sigHold_reg;
  logic [CHARGE_W-1:0] outRef_reg;
  logic [CHARGE_W-1:0] outSig_reg;
  logic                bloom_reg;
  logic                noise_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [CHARGE_W-1:0] clampAdd(input logic [CHARGE_W-1:0] a,
                                                   input logic [CHARGE_W-1:0] b);
    logic [CHARGE_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    // Charge beyond capacity spills sideways rather than wrapping
    clampAdd = (s > {1'b0, HREG_CAP}) ? HREG_CAP : s[CHARGE_W-1:0];
  endfunction

  wire vShiftEdge = edges.rise[PIN_VSHIFT];
  wire dumpLevel  = edges.level[PIN_DUMP];
  wire hFallEdge  = edges.fall[PIN_HCLK];
  wire resetRise  = edges.rise[PIN_RESET];
  wire refFall    = edges.fall[PIN_REFS];
  wire sigFall    = edges.fall[PIN_SIGS];
  wire xferRise   = edges.rise[PIN_XFER];
  wire hregEmpty  = (pixIdx_reg == HREG_LEN);
  wire rowToDrain = vShiftEdge & dumpLevel;
  wire rowToHreg  = vShiftEdge & ~dumpLevel;
  // Cells fed by columns follow the first eight, which stay empty; no empty cells at the far end
  wire pixCharged = (pixIdx_reg >= HREG_EDGE) && (pixIdx_reg < HREG_EDGE + HREG_COLS);
  wire [CHARGE_W-1:0] pixCharge = pixCharged ? lineCharge_reg : REF_LEVEL;
  wire readoutBusy = ~hregEmpty & (pixIdx_reg != PIX_ZERO);
  wire quietBreak  = readoutBusy & (edges.level[PIN_VSHIFT] | dumpLevel | shutSync_reg);

  // ----------------------------------------------------------------
  // Horizontal register: binning sums rows until it is drained
  // ----------------------------------------------------------------
  always_comb begin
    lineCharge_next = lineCharge_reg;
    pixIdx_next     = pixIdx_reg;
    if (rowToHreg) begin
      pixIdx_next = PIX_ZERO;
      if (hregEmpty) begin
        lineCharge_next = rowLevel;
      end else begin
        lineCharge_next = clampAdd(lineCharge_reg, rowLevel);
      end
    end else if (hFallEdge && !hregEmpty) begin
      pixIdx_next = pixIdx_reg + ONE_PIX;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lineCharge_reg <= REF_LEVEL;
      pixIdx_reg     <= HREG_LEN;
      bloom_reg      <= 1'b0;
    end else begin
      lineCharge_reg <= lineCharge_next;
      pixIdx_reg     <= pixIdx_next;
      if (rowToHreg && !hregEmpty) begin
        bloom_reg <= ({1'b0, lineCharge_reg} + {1'b0, rowLevel}) > {1'b0, HREG_CAP};
      end else if (rowToHreg) begin
        bloom_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drain counter, cleared by a load into the horizontal register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dumped_reg <= DUMP_ZERO;
    end else if (rowToDrain) begin
      dumped_reg <= dumped_reg + ONE_PIX;
    end else if (rowToHreg) begin
      dumped_reg <= DUMP_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Double sampler
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_reg   <= REF_LEVEL;
      refHold_reg <= REF_LEVEL;
      sigHold_reg <= REF_LEVEL;
      outRef_reg  <= REF_LEVEL;
      outSig_reg  <= REF_LEVEL;
    end else begin
      if (resetRise) begin
        sense_reg <= REF_LEVEL;
      end else if (hFallEdge) begin
        sense_reg <= hregEmpty ? REF_LEVEL : pixCharge;
      end
      if (refFall) begin
        refHold_reg <= sense_reg;
      end
      if (sigFall) begin
        sigHold_reg <= sense_reg;
      end
      // Outputs change only on transfer, so a pixel shows one period late
      if (xferRise) begin
        outRef_reg <= refHold_reg;
        outSig_reg <= sigHold_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Noise flag when quiet inputs move during readout
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shutMeta_reg <= 1'b0;
      shutSync_reg <= 1'b0;
      noise_reg    <= 1'b0;
    end else begin
      shutMeta_reg <= shutter_trigger;
      shutSync_reg <= shutMeta_reg;
      // Sticky until the next row load; a new offence in that cycle wins
      if (quietBreak) begin
        noise_reg <= 1'b1;
      end else if (rowToHreg) begin
        noise_reg <= 1'b0;
      end
    end
  end

  assign video_out_ref = outRef_reg;
  assign video_out_sig = outSig_reg;
  assign dumpedRows    = dumped_reg;
  assign pixelsLeft    = HREG_LEN - pixIdx_reg;
  assign hregBloom     = bloom_reg;
  assign readoutNoise  = noise_reg;
endmodule // cld_sensor_core

/* File: cld_timing_gen.sv */
// Timing generator model driving the sensor pins
// Assumes callers step it on the one sys_clk
`timescale 1ns/1ns
module cld_timing_gen (
  input wire logic sys_clk,
  output logic     vShift,
  output logic     dumpCtl,
  output logic     hClk,
  output logic     resetP,
  output logic     refS,
  output logic     sigS,
  output logic     xferP
);
  // ----
  // Pin sequences
  // ----
  initial {vShift, dumpCtl, hClk, resetP, refS, sigS, xferP} = 7'h00;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Dump only changes between lines, never while pixels move
  task automatic vshift(input logic dump);
    dumpCtl = dump;
    step(3);
    vShift = 1'b1;
    step(4);
    vShift = 1'b0;
    step(4);
  endtask
  // 15-clock pixel; 3 clocks is the narrowest pulse it drives
  task automatic pixel;
    hClk = 1'b1;
    resetP = 1'b1;
    xferP = 1'b1;
    step(5);
    resetP = 1'b0;
    xferP = 1'b0;
    step(1);
    refS = 1'b1;
    step(3);
    refS = 1'b0;
    step(1);
    hClk = 1'b0;
    step(1);
    sigS = 1'b1;
    step(3);
    sigS = 1'b0;
    step(1);
  endtask
endmodule // cld_timing_gen

/* File: testbench.sv */
// Self-checking bench for the sensor core
// Assumes the core synchronises its own pins
`timescale 1ns/1ns
module testbench;
  import cld_pkg::*;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic                shutter = 1'b0;
  logic [CHARGE_W-1:0] rowLevel = 14'h0000;
  logic [CHARGE_W-1:0] vRef, vSig;
  logic [DUMP_W-1:0]   dumped;
  logic [PIX_W-1:0]    left;
  logic                bloom, noise, vsh, fd, hck, rp, rs, ss, xp;
  int                  fail_count = 0;
  int                  total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  cld_sensor_core i_cld_sensor_core (
    .sys_clk(sys_clk), .rst(rst), .vertical_shift_reg(vsh), .line_dump_ctl(fd),
    .hreg_output_clock(hck), .senseResetPulse(rp), .ref_sample_pulse(rs),
    .sig_sample_pulse(ss), .holdTransferPulse(xp), .shutter_trigger(shutter),
    .rowLevel(rowLevel), .video_out_ref(vRef), .video_out_sig(vSig),
    .dumpedRows(dumped), .pixelsLeft(left), .hregBloom(bloom), .readoutNoise(noise)
  );
  cld_timing_gen gen (
    .sys_clk(sys_clk), .vShift(vsh), .dumpCtl(fd), .hClk(hck), .resetP(rp),
    .refS(rs), .sigS(ss), .xferP(xp)
  );
  // ----
  // Scenarios
  // ----
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    gen.step(2);
    rst = 1'b0;
  endtask
  // The first eight cells of the register carry no charge
  function automatic logic [13:0] pix(input int j, input logic [13:0] q);
    return (j >= int'(HREG_EDGE) && j < int'(HREG_LEN)) ? q : 14'h0000;
  endfunction
  // Dumped rows carry a level that must never reach the outputs
  task automatic t_line;
    rowLevel = 14'h3ABC;
    gen.vshift(1'b1);
    gen.vshift(1'b1);
    gen.step(2);
    chk(14'(dumped), 14'h0002);
    chk(14'(left), 14'h0000);
    rowLevel = 14'h0123;
    gen.vshift(1'b0);
    gen.step(2);
    chk(14'(dumped), 14'h0000);
    chk(14'(left), 14'(HREG_LEN));
    for (int i = 0; i <= int'(HREG_LEN); i++) begin
      gen.pixel();
      if (i > 0) chk(vSig, pix(i - 1, 14'h0123));
    end
    chk(14'(left), 14'h0000);
    chk(vRef, REF_LEVEL);
  endtask
  task automatic t_bin;
    do_reset();
    rowLevel = FULL_ROW;
    gen.vshift(1'b0);
    gen.vshift(1'b0);
    gen.step(2);
    chk(14'(bloom), 14'h0000);
    gen.vshift(1'b0);
    gen.step(2);
    chk(14'(bloom), 14'h0001);
    repeat (10) gen.pixel();
    chk(vSig, HREG_CAP);
    shutter = 1'b1;
    gen.step(4);
    shutter = 1'b0;
    gen.step(6);
    chk(14'(noise), 14'h0001);
    do_reset();
    chk(14'(noise), 14'h0000);
  endtask
  initial begin
    gen.step(2);
    rst = 1'b0;
    t_line();
    t_bin();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
endmodule // testbench
